// ---- hw/qthm_pkg.sv ----
// constants, register map and carrier types of the queue threshold and multicast hash block
// Overview of operation
// - held frame count captured at receive interrupt
// - read-write frame limit in low byte
// - threshold mode: interrupt when count exceeds limit
// - monitor on: interrupt when free space suffices
// - hash index is top six crc bits
// - index top bits pick word, rest bit
// - hash table used only in hash mode
// - table bit one accepts, zero drops
// - accept-all or multicast-all bypasses table
// - receive flag means a frame is waiting
// - space flag means transmit space became free
// - both flags edge-set, cleared by writing one
package qthm_pkg;

  localparam int ADDR_W = 12;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_FRAME_COUNT   = 10'h09c;
  localparam logic [9:0] IDX_SPACE_REQUEST = 10'h09e;
  localparam logic [9:0] IDX_HASH_WORD0    = 10'h0a0;
  localparam logic [9:0] IDX_HASH_WORD1    = 10'h0a2;
  localparam logic [9:0] IDX_HASH_WORD2    = 10'h0a4;
  localparam logic [9:0] IDX_HASH_WORD3    = 10'h0a6;
  localparam logic [9:0] IDX_RX_QUEUE_CTRL = 10'h0d0;
  localparam logic [9:0] IDX_TX_QUEUE_CTRL = 10'h0d2;
  localparam logic [9:0] IDX_RX_CONTROL1   = 10'h0d4;
  localparam logic [9:0] IDX_INT_STATUS    = 10'h0d6;
  localparam logic [9:0] IDX_INT_MASK      = 10'h0d8;
  localparam logic [9:0] IDX_QUEUE_STATE   = 10'h0da;

  // field positions
  localparam int RXQ_THRESH_EN_BIT  = 5;
  localparam int TXQ_MEM_MON_BIT    = 1;
  localparam int RXC1_ALL_MCAST_BIT = 1;
  localparam int RXC1_ALL_FRAME_BIT = 0;
  localparam int RXC1_HASH_MODE_BIT = 2;
  localparam int INT_RX_BIT         = 13;
  localparam int INT_TXSPACE_BIT    = 6;
  localparam int DA_GROUP_BIT       = 40;

  // reset values
  localparam logic [7:0]  LIMIT_RESET = 8'h00;
  localparam logic [7:0]  HELD_RESET  = 8'h00;
  localparam logic [15:0] REG16_RESET = 16'h0000;
  localparam logic [63:0] HASH_RESET  = 64'h0000_0000_0000_0000;

  // crc
  localparam logic [31:0] CRC_POLY = 32'h04c1_1db7;
  localparam logic [31:0] CRC_INIT = 32'hffff_ffff;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // live queue state from the queue manager
  typedef struct packed {
    logic [7:0]  rx_frames;
    logic [15:0] tx_free_dw;
  } qthm_queue_t;

  // destination address offered for filtering
  typedef struct packed {
    logic        valid;
    logic [47:0] da;
  } qthm_da_t;

  // filter verdict
  typedef struct packed {
    logic       valid;
    logic       accept;
    logic       hash_used;
    logic [5:0] index;
  } qthm_verdict_t;

endpackage

// ---- hw/qthm_hash.sv ----
// crc hash index of a destination address
`timescale 1ns/10ps
module qthm_hash
(
  // address, first byte in bits 47:40
  input  wire logic [47:0] da,
  // six-bit table index
  output logic [5:0]       index
);

  logic [31:0] chain [0:48];
  logic [47:0] wire_bits;

  assign chain[0] = qthm_pkg::CRC_INIT;

  // bytes go out first to last, each least significant bit first
  genvar g;
  generate
    for (g = 0; g < 48; g++)
    begin : g_bit
      localparam int BYTE = g / 8;
      localparam int BIT  = g % 8;
      assign wire_bits[g] = da[47 - 8 * BYTE - 7 + BIT];
      // one shift of the ethernet crc per address bit
      assign chain[g + 1] = {chain[g][30:0], 1'b0}
                          ^ ((chain[g][31] ^ wire_bits[g]) ? qthm_pkg::CRC_POLY : 32'h0000_0000);
    end
  endgenerate

  assign index = chain[48][31:26];

endmodule // qthm_hash

// ---- hw/qthm_top.sv ----
// frame threshold, transmit space request and multicast hash filter with axi4-lite registers
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module qthm_top
(
  // clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // axi4-lite write address
  input  wire logic                     awvalid,
  output logic                          awready,
  input  wire logic [qthm_pkg::ADDR_W-1:0] awaddr,
  input  wire logic [2:0]               awprot,
  // axi4-lite write data
  input  wire logic                     wvalid,
  output logic                          wready,
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  // axi4-lite write response
  output logic                          bvalid,
  input  wire logic                     bready,
  output logic [1:0]                    bresp,
  // axi4-lite read address
  input  wire logic                     arvalid,
  output logic                          arready,
  input  wire logic [qthm_pkg::ADDR_W-1:0] araddr,
  input  wire logic [2:0]               arprot,
  // axi4-lite read data
  output logic                          rvalid,
  input  wire logic                     rready,
  output logic [31:0]                   rdata,
  output logic [1:0]                    rresp,
  // queue manager side
  input  wire qthm_pkg::qthm_queue_t    queue,
  input  wire qthm_pkg::qthm_da_t       rx_da,
  output qthm_pkg::qthm_verdict_t       verdict,
  // interrupt
  output logic                          irq
);

  // held write channels
  logic                          aw_full;
  logic                          w_full;
  logic [qthm_pkg::ADDR_W-1:0]   aw_addr;
  logic [31:0]                   w_data;
  logic [3:0]                    w_strb;

  // software state
  logic [7:0]  rx_frames_limit;
  logic [7:0]  rx_frames_held;
  logic [15:0] tx_space_needed;
  logic [63:0] hash_table;
  logic [15:0] rx_queue_control;
  logic [15:0] tx_queue_control;
  logic [15:0] rx_control_one;
  logic [15:0] interrupt_status;
  logic [15:0] interrupt_mask;

  // event edge history
  logic rx_cond_q;
  logic tx_cond_q;

  // write decode
  logic [9:0]  wr_idx;
  logic        wr_go;
  logic [15:0] wr_mask;
  logic [15:0] wr_val;
  logic        wr_limit;
  logic        wr_space;
  logic        wr_rxq;
  logic        wr_txq;
  logic        wr_rxc1;
  logic        wr_stat;
  logic        wr_mask_reg;
  logic        wr_hit;
  logic [3:0]  wr_hash;

  assign wr_idx      = aw_addr[qthm_pkg::ADDR_W-1:2];
  assign wr_go       = aw_full & w_full & ~bvalid;
  assign wr_mask     = {{8{w_strb[1]}}, {8{w_strb[0]}}};
  assign wr_val      = w_data[15:0];
  assign wr_limit    = wr_go & (wr_idx == qthm_pkg::IDX_FRAME_COUNT);
  assign wr_space    = wr_go & (wr_idx == qthm_pkg::IDX_SPACE_REQUEST);
  assign wr_rxq      = wr_go & (wr_idx == qthm_pkg::IDX_RX_QUEUE_CTRL);
  assign wr_txq      = wr_go & (wr_idx == qthm_pkg::IDX_TX_QUEUE_CTRL);
  assign wr_rxc1     = wr_go & (wr_idx == qthm_pkg::IDX_RX_CONTROL1);
  assign wr_stat     = wr_go & (wr_idx == qthm_pkg::IDX_INT_STATUS);
  assign wr_mask_reg = wr_go & (wr_idx == qthm_pkg::IDX_INT_MASK);
  assign wr_hash[0]  = wr_go & (wr_idx == qthm_pkg::IDX_HASH_WORD0);
  assign wr_hash[1]  = wr_go & (wr_idx == qthm_pkg::IDX_HASH_WORD1);
  assign wr_hash[2]  = wr_go & (wr_idx == qthm_pkg::IDX_HASH_WORD2);
  assign wr_hash[3]  = wr_go & (wr_idx == qthm_pkg::IDX_HASH_WORD3);
  assign wr_hit      = wr_limit | wr_space | wr_rxq | wr_txq | wr_rxc1
                     | wr_stat | wr_mask_reg | (|wr_hash);

  // interrupt events: each flag is set on the rising edge of its condition
  logic thresh_en;
  logic mem_mon_en;
  logic rx_cond;
  logic tx_cond;
  logic rx_event;
  logic tx_event;
  logic [15:0] set_bits;
  logic [15:0] clr_bits;
  logic [15:0] next_status;

  assign thresh_en  = rx_queue_control[qthm_pkg::RXQ_THRESH_EN_BIT];
  assign mem_mon_en = tx_queue_control[qthm_pkg::TXQ_MEM_MON_BIT];
  // without threshold mode any waiting frame raises the flag
  assign rx_cond    = thresh_en ? (queue.rx_frames > rx_frames_limit)
                                : (queue.rx_frames != 8'h00);
  assign tx_cond    = mem_mon_en & (queue.tx_free_dw >= tx_space_needed);
  assign rx_event   = rx_cond & ~rx_cond_q;
  assign tx_event   = tx_cond & ~tx_cond_q;

  // the two flags are the only live bits; the rest read zero
  always_comb
  begin
    set_bits = 16'h0000;
    set_bits[qthm_pkg::INT_RX_BIT] = rx_event;
    set_bits[qthm_pkg::INT_TXSPACE_BIT] = tx_event;
  end

  assign clr_bits    = wr_stat ? (wr_val & wr_mask) : 16'h0000;
  // a set in the clearing cycle wins so no event is lost
  assign next_status = (interrupt_status & ~clr_bits) | set_bits;

  // status, edge history and held count
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      interrupt_status <= qthm_pkg::REG16_RESET;
      rx_cond_q        <= 1'b0;
      tx_cond_q        <= 1'b0;
      rx_frames_held   <= qthm_pkg::HELD_RESET;
      irq              <= 1'b0;
    end
    else
    begin
      interrupt_status <= next_status;
      rx_cond_q        <= rx_cond;
      tx_cond_q        <= tx_cond;
      if (rx_event)
        rx_frames_held <= queue.rx_frames;
      irq              <= |(next_status & interrupt_mask);
    end
  end

  // software-written registers, byte lanes honoured
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_frames_limit  <= qthm_pkg::LIMIT_RESET;
      tx_space_needed  <= qthm_pkg::REG16_RESET;
      rx_queue_control <= qthm_pkg::REG16_RESET;
      tx_queue_control <= qthm_pkg::REG16_RESET;
      rx_control_one   <= qthm_pkg::REG16_RESET;
      interrupt_mask   <= qthm_pkg::REG16_RESET;
    end
    else
    begin
      if (wr_limit & w_strb[0])
        rx_frames_limit <= wr_val[7:0];
      if (wr_space)
        tx_space_needed <= (tx_space_needed & ~wr_mask) | (wr_val & wr_mask);
      if (wr_rxq)
        rx_queue_control <= (rx_queue_control & ~wr_mask) | (wr_val & wr_mask);
      if (wr_txq)
        tx_queue_control <= (tx_queue_control & ~wr_mask) | (wr_val & wr_mask);
      if (wr_rxc1)
        rx_control_one <= (rx_control_one & ~wr_mask) | (wr_val & wr_mask);
      if (wr_mask_reg)
        interrupt_mask <= (interrupt_mask & ~wr_mask) | (wr_val & wr_mask);
    end
  end

  // hash table words, one per generate entry
  genvar gw;
  generate
    for (gw = 0; gw < 4; gw++)
    begin : g_hash
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          hash_table[16*gw +: 16] <= qthm_pkg::HASH_RESET[16*gw +: 16];
        else if (wr_hash[gw])
          hash_table[16*gw +: 16] <= (hash_table[16*gw +: 16] & ~wr_mask) | (wr_val & wr_mask);
      end
    end
  endgenerate

  // write channels: address and data taken in either order, one write at a time
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= qthm_pkg::RESP_OKAY;
      aw_addr <= '0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end
    else
    begin
      if (awvalid & awready)
      begin
        aw_full <= 1'b1;
        awready <= 1'b0;
        aw_addr <= awaddr;
      end
      if (wvalid & wready)
      begin
        w_full <= 1'b1;
        wready <= 1'b0;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (wr_go)
      begin
        aw_full <= 1'b0;
        w_full  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_hit ? qthm_pkg::RESP_OKAY : qthm_pkg::RESP_SLVERR;
      end
      if (bvalid & bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // read decode; read-only fields ignore writes by construction
  logic [9:0]  rd_idx;
  logic [31:0] rd_word;
  logic        rd_hit;

  assign rd_idx = araddr[qthm_pkg::ADDR_W-1:2];

  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case (rd_idx)
      qthm_pkg::IDX_FRAME_COUNT:   rd_word[15:0] = {rx_frames_held, rx_frames_limit};
      qthm_pkg::IDX_SPACE_REQUEST: rd_word[15:0] = tx_space_needed;
      qthm_pkg::IDX_HASH_WORD0:    rd_word[15:0] = hash_table[15:0];
      qthm_pkg::IDX_HASH_WORD1:    rd_word[15:0] = hash_table[31:16];
      qthm_pkg::IDX_HASH_WORD2:    rd_word[15:0] = hash_table[47:32];
      qthm_pkg::IDX_HASH_WORD3:    rd_word[15:0] = hash_table[63:48];
      qthm_pkg::IDX_RX_QUEUE_CTRL: rd_word[15:0] = rx_queue_control;
      qthm_pkg::IDX_TX_QUEUE_CTRL: rd_word[15:0] = tx_queue_control;
      qthm_pkg::IDX_RX_CONTROL1:   rd_word[15:0] = rx_control_one;
      qthm_pkg::IDX_INT_STATUS:    rd_word[15:0] = interrupt_status;
      qthm_pkg::IDX_INT_MASK:      rd_word[15:0] = interrupt_mask;
      qthm_pkg::IDX_QUEUE_STATE:   rd_word = {queue.tx_free_dw, 8'h00, queue.rx_frames};
      default:                     rd_hit = 1'b0;
    endcase
  end

  // read channel: data one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= qthm_pkg::RESP_OKAY;
    end
    else if (arvalid & arready)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_word;
      rresp   <= rd_hit ? qthm_pkg::RESP_OKAY : qthm_pkg::RESP_SLVERR;
    end
    else if (rvalid & rready)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // multicast filter
  logic [5:0] hash_index;
  logic [15:0] hash_word;
  logic       hash_bit;
  logic       is_mcast;
  logic       hash_mode;
  logic       bypass;
  logic       next_accept;

  qthm_hash u_hash
  (
    .da    (rx_da.da),
    .index (hash_index)
  );

  // top two index bits pick the word, low four the bit
  assign hash_word   = hash_table[16*hash_index[5:4] +: 16];
  assign hash_bit    = hash_word[hash_index[3:0]];
  // group bit is the first bit on the wire
  assign is_mcast    = rx_da.da[qthm_pkg::DA_GROUP_BIT];
  assign hash_mode   = rx_control_one[qthm_pkg::RXC1_HASH_MODE_BIT];
  assign bypass      = rx_control_one[qthm_pkg::RXC1_ALL_FRAME_BIT]
                     | rx_control_one[qthm_pkg::RXC1_ALL_MCAST_BIT];
  // other filtering modes decide elsewhere, so they pass here
  assign next_accept = ~is_mcast | bypass | ~hash_mode | hash_bit;

  // one-cycle verdict per offered address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      verdict <= '0;
    else
    begin
      verdict.valid     <= rx_da.valid;
      verdict.accept    <= rx_da.valid & next_accept;
      verdict.hash_used <= rx_da.valid & is_mcast & hash_mode & ~bypass;
      verdict.index     <= hash_index;
    end
  end

  // protection bits carry no meaning for these registers
  logic unused_prot;
  assign unused_prot = ^{awprot, arprot, w_data[31:16]};

endmodule // qthm_top

// ---- tb/qthm_checker.sv ----
// assertions on the ports of the queue threshold and hash block
`timescale 1ns/10ps
module qthm_checker
(
  // clock and reset
  input wire logic                    aclk,
  input wire logic                    aresetn,
  // register bus
  input wire logic                    awvalid,
  input wire logic                    awready,
  input wire logic                    wvalid,
  input wire logic                    wready,
  input wire logic                    bvalid,
  input wire logic                    arvalid,
  input wire logic                    arready,
  input wire logic [11:0]             araddr,
  input wire logic                    rvalid,
  input wire logic                    rready,
  input wire logic [31:0]             rdata,
  input wire logic [1:0]              rresp,
  // filter
  input wire qthm_pkg::qthm_da_t      rx_da,
  input wire qthm_pkg::qthm_verdict_t verdict
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // channels held one edge, response raised the next: seen two edges on
  property p_b_answer;
    awvalid && awready && wvalid && wready |-> ##2 bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("no write response");
  property p_r_answer;
    arvalid && arready |=> rvalid && !arready;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("no read response");
  // read data may not wander while the host stalls
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_unmapped;
    arvalid && arready && araddr == 12'h004 |=> rresp == 2'h2 && rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_verdict;
    rx_da.valid |=> verdict.valid;
  endproperty
  a_verdict: assert property (p_verdict) else $error("no verdict");
  property p_verdict_cause;
    verdict.valid |-> $past(rx_da.valid);
  endproperty
  a_verdict_cause: assert property (p_verdict_cause) else $error("verdict without address");
  property p_unicast;
    rx_da.valid && !rx_da.da[40] |=> verdict.accept;
  endproperty
  a_unicast: assert property (p_unicast) else $error("individual address dropped");
  property p_drop_hash;
    verdict.valid && !verdict.accept |-> verdict.hash_used;
  endproperty
  a_drop_hash: assert property (p_drop_hash) else $error("drop without table");
endmodule // qthm_checker

bind qthm_top qthm_checker u_chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid), .arready(arready), .araddr(araddr),
  .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .rx_da(rx_da), .verdict(verdict));

// ---- tb/qthm_queue_model.sv ----
// queue manager model: queue levels and destination address offers
`timescale 1ns/10ps
module qthm_queue_model
(
  // clock
  input wire logic              aclk,
  // queue manager outputs
  output qthm_pkg::qthm_queue_t queue,
  output qthm_pkg::qthm_da_t    rx_da
);
  initial
  begin
    queue = '0;
    rx_da = '0;
  end

  // levels change just after an edge
  task automatic set_q(input logic [7:0] rx, input logic [15:0] tx);
    @(posedge aclk);
    queue <= '{rx_frames: rx, tx_free_dw: tx};
  endtask

  // one-cycle offer; released address shows inverted bits so stale data is never trusted
  task automatic offer(input logic [47:0] da);
    @(posedge aclk);
    rx_da <= '{valid: 1'b1, da: da};
    @(posedge aclk);
    rx_da <= '{valid: 1'b0, da: ~da};
    @(negedge aclk);
  endtask
endmodule // qthm_queue_model

// ---- tb/queue_threshold_and_multicast_hash_bench.sv ----
// self-checking bench of the queue threshold and multicast hash block
`timescale 1ns/10ps
module queue_threshold_and_multicast_hash_bench;
  logic                    aclk = 1'b0;
  logic                    aresetn = 1'b0;
  logic                    awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic                    awready, wready, bvalid, arready, rvalid, irq;
  logic [11:0]             awaddr = 12'h000, araddr = 12'h000;
  logic [31:0]             wdata = 32'h0, rdata, rd;
  logic [3:0]              wstrb = 4'h0;
  logic [1:0]              bresp, rresp, rs;
  logic [5:0]              idx;
  qthm_pkg::qthm_queue_t   queue;
  qthm_pkg::qthm_da_t      rx_da;
  qthm_pkg::qthm_verdict_t verdict;
  int                      error_cnt = 0;
  int                      tests_run = 0;

  always #50 aclk = ~aclk;

  qthm_top DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .queue(queue), .rx_da(rx_da),
    .verdict(verdict), .irq(irq));
  qthm_queue_model QM (.aclk(aclk), .queue(queue), .rx_da(rx_da));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // address and data offered together, each released once taken
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic aw_on;
    logic w_on;
    aw_on = 1'b1;
    w_on = 1'b1;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {16'h0000, d};
    wstrb <= 4'h3;
    bready <= 1'b1;
    while (aw_on || w_on)
    begin
      @(posedge aclk);
      if (aw_on && awready)
      begin
        aw_on = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_on && wready)
      begin
        w_on = 1'b0;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid)
      @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r, input bit stall = 1'b0);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= !stall;
    @(posedge aclk);
    while (!arready)
      @(posedge aclk);
    arvalid <= 1'b0;
    @(posedge aclk);
    while (!rvalid)
      @(posedge aclk);
    if (stall)
    begin
      // answer left waiting one cycle; it must stand
      rready <= 1'b1;
      @(posedge aclk);
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    rdr(a, rd, rs);
    chk(rd, e);
  endtask

  // reference hash: ethernet crc, bytes first to last, lsb first
  function automatic logic [5:0] hash_of(input logic [47:0] da);
    logic [31:0] c;
    logic        fb;
    c = 32'hffff_ffff;
    for (int i = 0; i < 48; i++)
    begin
      fb = c[31] ^ da[40 - 8 * (i / 8) + (i % 8)];
      c = {c[30:0], 1'b0} ^ (fb ? qthm_pkg::CRC_POLY : 32'h0);
    end
    return c[31:26];
  endfunction

  // e is {hash used, accept, index}
  task automatic offer_chk(input logic [47:0] da, input logic [7:0] e);
    QM.offer(da);
    chk({23'h0, verdict.valid, verdict.hash_used, verdict.accept, verdict.index}, {23'h0, 1'b1, e});
  endtask

  task automatic t_reset();
    rchk(12'h270, 32'h0);
    rchk(12'h278, 32'h0);
    for (int k = 0; k < 4; k++)
      rchk(12'h280 + 12'(8 * k), 32'h0);
    // unmapped read answered late by the host; the refusal must stand
    rdr(12'h004, rd, rs, 1'b1);
    chk({rs, rd[29:0]}, 32'h8000_0000);
    wr(12'h004, 16'h1234);
    chk({30'h0, bresp}, 32'h0000_0002);
  endtask

  // held count is read-only, limit and space request read back
  task automatic t_fields();
    wr(12'h270, 16'hffff);
    rchk(12'h270, 32'h0000_00ff);
    wr(12'h270, 16'h0002);
    rchk(12'h270, 32'h0000_0002);
    wr(12'h278, 16'h0010);
    chk({30'h0, bresp}, 32'h0000_0000);
    rchk(12'h278, 32'h0000_0010);
    // threshold mode off: any waiting frame raises the flag
    QM.set_q(8'd1, 16'h0000);
    repeat (3) @(posedge aclk);
    rchk(12'h358, 32'h0000_2000);
    rchk(12'h270, 32'h0000_0102);
    wr(12'h358, 16'h2000);
  endtask

  task automatic t_rx_thresh();
    wr(12'h360, 16'h2040);
    wr(12'h340, 16'h0020);
    QM.set_q(8'd2, 16'h0000);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    QM.set_q(8'd3, 16'h0000);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    rchk(12'h270, 32'h0000_0302);
    rchk(12'h368, 32'h0000_0003);
    rchk(12'h358, 32'h0000_2000);
    wr(12'h358, 16'h2000);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    rchk(12'h358, 32'h0);
  endtask

  // space one short, then enough; then masked and cleared
  task automatic t_tx_space();
    QM.set_q(8'd3, 16'h000f);
    wr(12'h348, 16'h0002);
    repeat (3) @(posedge aclk);
    rchk(12'h358, 32'h0);
    QM.set_q(8'd3, 16'h0010);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    rchk(12'h358, 32'h0000_0040);
    wr(12'h360, 16'h2000);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    wr(12'h358, 16'h0040);
    rchk(12'h358, 32'h0);
  endtask

  task automatic t_hash();
    logic [47:0] mc;
    mc = 48'h0100_5e00_00fb;
    idx = hash_of(mc);
    wr(12'h350, 16'h0004);
    wr(12'h280 + {4'h0, idx[5:4], 6'h0} / 12'h8, 16'h0001 << idx[3:0]);
    offer_chk(mc, {2'h3, idx});
    wr(12'h280 + {4'h0, idx[5:4], 6'h0} / 12'h8, 16'h0000);
    offer_chk(mc, {2'h2, idx});
    offer_chk(48'h0200_0000_0001, {2'h1, hash_of(48'h0200_0000_0001)});
    wr(12'h350, 16'h0006);
    offer_chk(mc, {2'h1, idx});
    wr(12'h350, 16'h0005);
    offer_chk(mc, {2'h1, idx});
    wr(12'h350, 16'h0000);
    offer_chk(mc, {2'h1, idx});
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_fields();
    t_rx_thresh();
    t_tx_space();
    t_hash();
    test_done();
  end

  // watchdog: the sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge aclk);
    error_cnt++;
    test_done();
  end
endmodule // queue_threshold_and_multicast_hash_bench
